/* core/perf_monitor_event_select.sv */
// performance monitor counters, event selection for counters three and four,
// sampled instruction address capture and special-register decode
// assumes: event pulses, time base and machine state come from logic on clk_sys;
// the first monitor control bits and the second control word arrive as levels
`timescale 1ns/100ps

module perf_monitor_event_select
	import perf_mon_pkg::*;
#(
	parameter bit MARK_FOUR_IN_USER = 1'b1
)(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire spr_req_s    sprReq,
	output logic             sprAck,
	output logic             sprHit,
	output logic [31:0]      sprRdData,
	input  wire logic [31:0] controlSecond,
	input  wire logic [1:0]  timeBaseBitSelect,
	input  wire logic        globalIrqEnable,
	input  wire logic        stopOnIrq,
	input  wire logic [3:0]  counterIrqControl,
	input  wire logic [1:0]  countOneInc,
	input  wire logic [1:0]  countTwoInc,
	input  wire common_ev_s  commonEv,
	input  wire three_ev_s   threeEv,
	input  wire four_ev_s    fourEv,
	input  wire logic [63:0] timeBase,
	input  wire logic        markedProcessBit,
	input  wire logic        userMode,
	input  wire logic        thresholdEvent,
	input  wire logic [31:0] thresholdAddr,
	input  wire logic [31:0] lastCompletedAddr,
	output logic             monitorIrq,
	output logic             countersFrozen,
	output logic [31:0]      sampledAddr
);

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// events shared by counters three and four; anything else counts zero
	function automatic logic [1:0] common_inc(
		input logic [4:0]  code,
		input common_ev_s  ev,
		input logic        tbRise
	);
		logic [1:0] inc;
		inc = 2'h0;
		case (code)
			EV_CYCLES:     inc = 2'h1;
			EV_COMPLETED:  inc = ev.completed;
			EV_TIME_BASE:  inc = {1'b0, tbRise};
			EV_DISPATCHED: inc = ev.dispatched;
			default:       inc = 2'h0;
		endcase
		return inc;
	endfunction : common_inc

	// counter three event decode; unlisted codes fall to zero
	function automatic logic [1:0] three_inc(
		input logic [4:0]  code,
		input common_ev_s  ev,
		input three_ev_s   e3,
		input logic        tbRise,
		input logic        markUser
	);
		logic hit;
		hit = 1'b0;
		case (code)
			EV_CODE_05:     hit = e3.l1DataMiss;
			EV_CODE_06:     hit = e3.dataTlbMiss;
			EV_CODE_07:     hit = e3.l2DataMiss;
			EV_CODE_08:     hit = e3.takenBranch;
			EV_MARK_TOGGLE: hit = markUser;
			EV_CODE_0A:     hit = e3.storeCondDone;
			EV_CODE_0B:     hit = e3.floatUnitDone;
			EV_CODE_0C:     hit = e3.l2SnoopCastout;
			EV_CODE_0D:     hit = e3.l2CacheOpHit;
			EV_CODE_0E:     hit = 1'b0;
			EV_CODE_0F:     hit = e3.l1LoadMissCycle;
			EV_CODE_10:     hit = e3.specTwoCorrect;
			EV_CODE_11:     hit = e3.branchUnitDepStall;
			default:        hit = 1'b0;
		endcase
		return common_inc(code, ev, tbRise) | {1'b0, hit};
	endfunction : three_inc

	// counter four event decode; code 7 and codes above 14 hold
	function automatic logic [1:0] four_inc(
		input logic [4:0]  code,
		input common_ev_s  ev,
		input four_ev_s    e4,
		input logic        tbRise,
		input logic        markSel
	);
		logic hit;
		hit = 1'b0;
		case (code)
			EV_CODE_05:     hit = e4.l2Castout;
			EV_CODE_06:     hit = e4.dataTlbSearchCycle;
			EV_CODE_07:     hit = 1'b0;
			EV_CODE_08:     hit = e4.mispredict;
			EV_MARK_TOGGLE: hit = markSel;
			EV_CODE_0A:     hit = e4.storeCondIntact;
			EV_CODE_0B:     hit = e4.syncDone;
			EV_CODE_0C:     hit = e4.snoopRetry;
			EV_CODE_0D:     hit = e4.integerDone;
			EV_CODE_0E:     hit = e4.branchUnitTwoStall;
			default:        hit = 1'b0;
		endcase
		return common_inc(code, ev, tbRise) | {1'b0, hit};
	endfunction : four_inc

	// advance a counter unless frozen or overwritten this cycle
	function automatic logic [31:0] step_counter(
		input logic [31:0] cur,
		input logic [1:0]  inc,
		input logic        frozen,
		input logic        wr,
		input logic [31:0] wrData
	);
		logic [31:0] res;
		res = cur;
		if (wr) begin
			res = wrData;
		end else if (!frozen) begin
			res = cur + {30'h0, inc};
		end
		return res;
	endfunction : step_counter

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] countOne_ff;
	logic [31:0] countTwo_ff;
	logic [31:0] countThree_ff;
	logic [31:0] countFour_ff;
	logic [31:0] sampled_ff;
	logic        irq_ff;
	logic        frozen_ff;
	logic        tbBitPrev_ff;
	logic        markPrev_ff;
	logic        histValid_ff;
	logic        ack_ff;
	logic        hit_ff;
	logic [31:0] rdData_ff;

	// ----------------------------------------------------------------
	// event conditioning
	// ----------------------------------------------------------------

	// time-base bit pick; big-endian bit n sits at little-endian 63-n
	logic [5:0] tbIndex;
	logic       tbBit;
	logic       tbRise;
	assign tbIndex = (timeBaseBitSelect == 2'h0) ? 6'(63 - TB_BIT_SEL0) :
	                 (timeBaseBitSelect == 2'h1) ? 6'(63 - TB_BIT_SEL1) :
	                 (timeBaseBitSelect == 2'h2) ? 6'(63 - TB_BIT_SEL2) :
	                                               6'(63 - TB_BIT_SEL3);
	assign tbBit   = timeBase[tbIndex];
	// no history right after reset: a bit already high there is not a rise
	assign tbRise  = tbBit & ~tbBitPrev_ff & histValid_ff;

	// marked-process toggles qualified by privilege level
	logic markToggle;
	logic markUser;
	logic markFour;
	// a mark already set at reset release is not a toggle
	assign markToggle = (markedProcessBit ^ markPrev_ff) & histValid_ff;
	assign markUser   = markToggle & userMode;
	// the mode for counter four is ambiguous; a parameter picks it
	assign markFour   = markToggle & (MARK_FOUR_IN_USER ? userMode : ~userMode);

	// ----------------------------------------------------------------
	// select fields and increments
	// ----------------------------------------------------------------
	logic [4:0] selThree;
	logic [4:0] selFour;
	logic [1:0] incThree;
	logic [1:0] incFour;
	assign selThree = controlSecond[SEL_THREE_LSB +: SEL_WIDTH];
	assign selFour  = controlSecond[SEL_FOUR_LSB +: SEL_WIDTH];
	assign incThree = three_inc(selThree, commonEv, threeEv, tbRise, markUser);
	assign incFour  = four_inc(selFour, commonEv, fourEv, tbRise, markFour);

	// ----------------------------------------------------------------
	// special-register decode
	// ----------------------------------------------------------------
	logic wrOne;
	logic wrTwo;
	logic wrThree;
	logic wrFour;
	logic wrSampled;
	logic isWrite;
	assign isWrite   = sprReq.valid & sprReq.write;
	assign wrOne     = isWrite & (sprReq.num == SPR_COUNTER_ONE);
	assign wrTwo     = isWrite & (sprReq.num == SPR_COUNTER_TWO);
	assign wrThree   = isWrite & (sprReq.num == SPR_COUNTER_THREE);
	assign wrFour    = isWrite & (sprReq.num == SPR_COUNTER_FOUR);
	assign wrSampled = isWrite & (sprReq.num == SPR_SAMPLED_ADDR);
	// mirror numbers decode for reads only, so a write there has no target

	// read mux; supervisor and user numbers share the same storage
	logic        rdHit;
	logic [31:0] rdValue;
	always_comb begin
		rdHit   = 1'b1;
		rdValue = 32'h0000_0000;
		case (sprReq.num)
			SPR_COUNTER_ONE,   SPR_USER_COUNTER_ONE:   rdValue = countOne_ff;
			SPR_COUNTER_TWO,   SPR_USER_COUNTER_TWO:   rdValue = countTwo_ff;
			SPR_COUNTER_THREE, SPR_USER_COUNTER_THREE: rdValue = countThree_ff;
			SPR_COUNTER_FOUR,  SPR_USER_COUNTER_FOUR:  rdValue = countFour_ff;
			SPR_SAMPLED_ADDR,  SPR_USER_SAMPLED_ADDR:  rdValue = sampled_ff;
			default:                                   rdHit   = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next counter values
	// ----------------------------------------------------------------
	logic [31:0] nxt_countOne;
	logic [31:0] nxt_countTwo;
	logic [31:0] nxt_countThree;
	logic [31:0] nxt_countFour;
	assign nxt_countOne   = step_counter(countOne_ff, countOneInc, frozen_ff, wrOne, sprReq.data);
	assign nxt_countTwo   = step_counter(countTwo_ff, countTwoInc, frozen_ff, wrTwo, sprReq.data);
	assign nxt_countThree = step_counter(countThree_ff, incThree, frozen_ff, wrThree, sprReq.data);
	assign nxt_countFour  = step_counter(countFour_ff, incFour, frozen_ff, wrFour, sprReq.data);

	// ----------------------------------------------------------------
	// overflow, interrupt, freeze and sampling
	// ----------------------------------------------------------------
	// looking at next values lets the sample land in the cycle of the event
	logic [3:0]  overflowed;
	logic        nxt_irq;
	logic        irqRise;
	logic        nxt_frozen;
	logic [31:0] nxt_sampled;
	assign overflowed = {nxt_countFour[COUNTER_MSB], nxt_countThree[COUNTER_MSB],
	                     nxt_countTwo[COUNTER_MSB],  nxt_countOne[COUNTER_MSB]};
	assign nxt_irq    = globalIrqEnable & |(overflowed & counterIrqControl);
	assign irqRise    = nxt_irq & ~irq_ff;
	// freeze lasts until software drops the stop-on-interrupt bit
	assign nxt_frozen = stopOnIrq & (frozen_ff | irqRise);
	// capture beats a same-cycle software write of the sampled register
	assign nxt_sampled = irqRise ? (thresholdEvent ? thresholdAddr
	                                               : lastCompletedAddr)
	                   : wrSampled ? sprReq.data : sampled_ff;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------

	// counters
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			countOne_ff   <= COUNTER_RESET;
			countTwo_ff   <= COUNTER_RESET;
			countThree_ff <= COUNTER_RESET;
			countFour_ff  <= COUNTER_RESET;
		end else begin
			countOne_ff   <= nxt_countOne;
			countTwo_ff   <= nxt_countTwo;
			countThree_ff <= nxt_countThree;
			countFour_ff  <= nxt_countFour;
		end
	end

	// interrupt, freeze, sample and edge history
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff       <= 1'b0;
			frozen_ff    <= 1'b0;
			sampled_ff   <= ADDR_RESET;
			tbBitPrev_ff <= 1'b0;
			markPrev_ff  <= 1'b0;
		end else begin
			irq_ff       <= nxt_irq;
			frozen_ff    <= nxt_frozen;
			sampled_ff   <= nxt_sampled;
			tbBitPrev_ff <= tbBit;
			markPrev_ff  <= markedProcessBit;
		end
	end

	// edge history becomes trustworthy one edge after reset release
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			histValid_ff <= 1'b0;
		end else begin
			histValid_ff <= 1'b1;
		end
	end

	// read answer one cycle after the request
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff    <= 1'b0;
			hit_ff    <= 1'b0;
			rdData_ff <= 32'h0000_0000;
		end else begin
			ack_ff    <= sprReq.valid;
			hit_ff    <= sprReq.valid & rdHit;
			rdData_ff <= (sprReq.valid & ~sprReq.write & rdHit) ? rdValue : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign sprAck         = ack_ff;
	assign sprHit         = hit_ff;
	assign sprRdData      = rdData_ff;
	assign monitorIrq     = irq_ff;
	assign countersFrozen = frozen_ff;
	assign sampledAddr    = sampled_ff;

endmodule : perf_monitor_event_select

/* common/perf_mon_pkg.sv */
// constants, codes and carrier structs for the performance monitor event block
// assumes one core clock; event pulses arrive already on that clock
package perf_mon_pkg;

	// ----------------------------------------------------------------
	// special-register numbers
	// ----------------------------------------------------------------
	localparam logic [9:0] SPR_USER_COUNTER_ONE   = 10'h3A9;
	localparam logic [9:0] SPR_USER_COUNTER_TWO   = 10'h3AA;
	localparam logic [9:0] SPR_USER_SAMPLED_ADDR  = 10'h3AB;
	localparam logic [9:0] SPR_USER_COUNTER_THREE = 10'h3AD;
	localparam logic [9:0] SPR_USER_COUNTER_FOUR  = 10'h3AE;
	localparam logic [9:0] SPR_COUNTER_ONE        = 10'h3B9;
	localparam logic [9:0] SPR_COUNTER_TWO        = 10'h3BA;
	localparam logic [9:0] SPR_SAMPLED_ADDR       = 10'h3BB;
	localparam logic [9:0] SPR_COUNTER_THREE      = 10'h3BD;
	localparam logic [9:0] SPR_COUNTER_FOUR       = 10'h3BE;

	// ----------------------------------------------------------------
	// field layout of the second monitor control word, reset values
	// ----------------------------------------------------------------
	localparam int           SEL_THREE_LSB  = 0;
	localparam int           SEL_FOUR_LSB   = 5;
	localparam int           SEL_WIDTH      = 5;
	localparam int           COUNTER_MSB    = 31;
	localparam logic [31:0]  COUNTER_RESET  = 32'h0000_0000;
	localparam logic [31:0]  ADDR_RESET     = 32'h0000_0000;

	// time-base-lower bit picked by the 2-bit select (big-endian bit numbers)
	localparam int TB_BIT_SEL0 = 47;
	localparam int TB_BIT_SEL1 = 51;
	localparam int TB_BIT_SEL2 = 55;
	localparam int TB_BIT_SEL3 = 63;

	// ----------------------------------------------------------------
	// event select codes
	// ----------------------------------------------------------------
	localparam logic [4:0] EV_HOLD        = 5'h00;
	localparam logic [4:0] EV_CYCLES      = 5'h01;
	localparam logic [4:0] EV_COMPLETED   = 5'h02;
	localparam logic [4:0] EV_TIME_BASE   = 5'h03;
	localparam logic [4:0] EV_DISPATCHED  = 5'h04;
	localparam logic [4:0] EV_CODE_05     = 5'h05;
	localparam logic [4:0] EV_CODE_06     = 5'h06;
	localparam logic [4:0] EV_CODE_07     = 5'h07;
	localparam logic [4:0] EV_CODE_08     = 5'h08;
	localparam logic [4:0] EV_MARK_TOGGLE = 5'h09;
	localparam logic [4:0] EV_CODE_0A     = 5'h0A;
	localparam logic [4:0] EV_CODE_0B     = 5'h0B;
	localparam logic [4:0] EV_CODE_0C     = 5'h0C;
	localparam logic [4:0] EV_CODE_0D     = 5'h0D;
	localparam logic [4:0] EV_CODE_0E     = 5'h0E;
	localparam logic [4:0] EV_CODE_0F     = 5'h0F;
	localparam logic [4:0] EV_CODE_10     = 5'h10;
	localparam logic [4:0] EV_CODE_11     = 5'h11;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] completed;   // 0..2 instructions completed, folded branches excluded
		logic [1:0] dispatched;  // 0..2 instructions dispatched
	} common_ev_s;

	typedef struct packed {
		logic l1DataMiss;
		logic dataTlbMiss;
		logic l2DataMiss;
		logic takenBranch;
		logic storeCondDone;
		logic floatUnitDone;
		logic l2SnoopCastout;
		logic l2CacheOpHit;
		logic l1LoadMissCycle;
		logic specTwoCorrect;
		logic branchUnitDepStall;
	} three_ev_s;

	typedef struct packed {
		logic l2Castout;
		logic dataTlbSearchCycle;
		logic mispredict;
		logic storeCondIntact;
		logic syncDone;
		logic snoopRetry;
		logic integerDone;
		logic branchUnitTwoStall;
	} four_ev_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [9:0]  num;
		logic [31:0] data;
	} spr_req_s;

endpackage : perf_mon_pkg

/* tb/perf_monitor_event_select_asserts.sv */
// port checks for the event monitor: register answers, interrupt, freeze, sample
// assumes: bound to the monitor top, one clock, reset active low
`timescale 1ns/100ps
module perf_monitor_event_select_asserts
	import perf_mon_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire spr_req_s    sprReq,
	input wire logic        sprAck,
	input wire logic        sprHit,
	input wire logic [31:0] sprRdData,
	input wire logic        globalIrqEnable,
	input wire logic        stopOnIrq,
	input wire logic        thresholdEvent,
	input wire logic [31:0] thresholdAddr,
	input wire logic [31:0] lastCompletedAddr,
	input wire logic        monitorIrq,
	input wire logic        countersFrozen,
	input wire logic [31:0] sampledAddr
);
	// --------------------
	// request decode
	// --------------------
	// mirrors are mapped too: they answer a write but must ignore it
	wire logic mapped = sprReq.num inside {SPR_USER_COUNTER_ONE, SPR_USER_COUNTER_TWO, SPR_USER_SAMPLED_ADDR,
		SPR_USER_COUNTER_THREE, SPR_USER_COUNTER_FOUR, SPR_COUNTER_ONE, SPR_COUNTER_TWO, SPR_SAMPLED_ADDR,
		SPR_COUNTER_THREE, SPR_COUNTER_FOUR};
	wire logic rdSample = sprReq.valid && !sprReq.write
		&& (sprReq.num == SPR_SAMPLED_ADDR || sprReq.num == SPR_USER_SAMPLED_ADDR);
	wire logic wrReq = sprReq.valid && sprReq.write;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// --------------------
	// properties
	// --------------------
	ack_after_req_a: assert property (sprReq.valid |=> sprAck)
		else $error("request not answered next cycle");
	no_stray_ack_a: assert property (!sprReq.valid |=> !sprAck)
		else $error("answer without request");
	unmapped_miss_a: assert property (sprReq.valid && !mapped |=> !sprHit && sprRdData == 32'h0000_0000)
		else $error("unmapped number answered as hit");
	mapped_hit_a: assert property (sprReq.valid && mapped |=> sprHit)
		else $error("mapped number missed");
	write_no_data_a: assert property (wrReq |=> sprRdData == 32'h0000_0000)
		else $error("write returned data");
	sample_read_a: assert property (rdSample |=> sprRdData == $past(sampledAddr))
		else $error("sampled address read wrong");
	irq_needs_enable_a: assert property (monitorIrq |-> $past(globalIrqEnable))
		else $error("interrupt without global enable");
	capture_addr_a: assert property ($rose(monitorIrq) |->
		sampledAddr == ($past(thresholdEvent) ? $past(thresholdAddr) : $past(lastCompletedAddr)))
		else $error("wrong address captured");
	freeze_cause_a: assert property ($rose(countersFrozen) |-> $rose(monitorIrq) && $past(stopOnIrq))
		else $error("freeze without interrupt");
	freeze_release_a: assert property (!stopOnIrq |=> !countersFrozen)
		else $error("freeze held without stop bit");
	mirror_ro_a: assert property (wrReq && sprReq.num == SPR_USER_SAMPLED_ADDR |=>
		$rose(monitorIrq) || $stable(sampledAddr)) else $error("mirror write changed sample");
	sample_write_a: assert property (wrReq && sprReq.num == SPR_SAMPLED_ADDR |=>
		$rose(monitorIrq) || sampledAddr == $past(sprReq.data)) else $error("sample write lost");
endmodule : perf_monitor_event_select_asserts

/* tb/event_source_model.sv */
// random event source in place of pipeline, caches and bus
// assumes: outputs change 1 ns after each rising clock edge
`timescale 1ns/100ps
module event_source_model
	import perf_mon_pkg::*;
(
	input  wire logic  clk_sys,
	output common_ev_s commonEv,
	output three_ev_s  threeEv,
	output four_ev_s   fourEv,
	output logic [63:0] timeBase,
	output logic       markedProcessBit,
	output logic       userMode,
	output logic [1:0] countOneInc,
	output logic [1:0] countTwoInc,
	output logic       thresholdEvent,
	output logic [31:0] thresholdAddr,
	output logic [31:0] lastCompletedAddr
);
	// quiet at time zero, then new traffic every cycle; one process drives every output
	// time base jumps so upper select bits also rise
	initial begin
		{commonEv, threeEv, fourEv, timeBase, markedProcessBit, userMode} = '0;
		{countOneInc, countTwoInc, thresholdEvent, thresholdAddr, lastCompletedAddr} = '0;
		forever begin
			@(posedge clk_sys);
			#1;
			commonEv.completed = 2'($urandom_range(2));
			commonEv.dispatched = 2'($urandom_range(2));
			threeEv = three_ev_s'($urandom);
			fourEv = four_ev_s'($urandom);
			timeBase = timeBase + 64'($urandom_range(300));
			{markedProcessBit, userMode, thresholdEvent} = 3'($urandom);
			countOneInc = 2'($urandom_range(2));
			countTwoInc = 2'($urandom_range(2));
			thresholdAddr = $urandom;
			lastCompletedAddr = $urandom;
		end
	end
endmodule : event_source_model

/* tb/test_perf_monitor_event_select.sv */
// bench for the event monitor: reference counters, register accesses,
// interrupt, freeze and sample compared every cycle
// assumes: checker and event source model compiled first
`timescale 1ns/100ps
module test_perf_monitor_event_select
	import perf_mon_pkg::*;
;
	localparam bit         MARK_FOUR = 1'b1;
	localparam logic [9:0] NUMS [11] = '{SPR_COUNTER_ONE, SPR_COUNTER_TWO, SPR_SAMPLED_ADDR, SPR_COUNTER_THREE,
		SPR_COUNTER_FOUR, SPR_USER_COUNTER_ONE, SPR_USER_COUNTER_TWO, SPR_USER_SAMPLED_ADDR,
		SPR_USER_COUNTER_THREE, SPR_USER_COUNTER_FOUR, 10'h3AC};
	localparam logic [4:0] T3 [11] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h11};
	localparam logic [4:0] T4 [8] = '{5'h05, 5'h06, 5'h08, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E};
	typedef struct packed {logic hit; logic [31:0] data;} note_s;

	logic        clk_sys           = 1'b0;
	logic        rst_n             = 1'b0;
	spr_req_s    sprReq            = '0;
	// counter four watches mark toggles across reset release: no false toggle may count
	logic [31:0] controlSecond     = 32'h0000_0120;
	logic [1:0]  timeBaseBitSelect = '0;
	logic        globalIrqEnable   = 1'b0;
	logic        stopOnIrq         = 1'b0;
	logic [3:0]  counterIrqControl = '0;
	logic        sprAck, sprHit, monitorIrq, countersFrozen, markedProcessBit, userMode, thresholdEvent;
	logic [31:0] sprRdData, sampledAddr, thresholdAddr, lastCompletedAddr, sampM;
	logic [1:0]  countOneInc, countTwoInc;
	logic [63:0] timeBase, tbPrev;
	common_ev_s  commonEv;
	three_ev_s   threeEv;
	four_ev_s    fourEv;
	logic [31:0] cntM [4];
	logic [31:0] nx [4];
	logic        irqM, frzM, markPrev, irqN, histM;
	note_s       notes [$];
	note_s       got;
	int          fails = 0;
	int          cmp_count = 0;
	wire logic   wrReq = sprReq.valid && sprReq.write;

	always #2 clk_sys = ~clk_sys;

	perf_monitor_event_select #(.MARK_FOUR_IN_USER(MARK_FOUR)) i_perf_monitor_event_select (.clk_sys, .rst_n, .sprReq,
		.sprAck, .sprHit, .sprRdData, .controlSecond, .timeBaseBitSelect, .globalIrqEnable, .stopOnIrq,
		.counterIrqControl, .countOneInc, .countTwoInc, .commonEv, .threeEv, .fourEv, .timeBase, .markedProcessBit,
		.userMode, .thresholdEvent, .thresholdAddr, .lastCompletedAddr, .monitorIrq, .countersFrozen, .sampledAddr);
	event_source_model i_event_source_model (.clk_sys, .commonEv, .threeEv, .fourEv, .timeBase, .markedProcessBit,
		.userMode, .countOneInc, .countTwoInc, .thresholdEvent, .thresholdAddr, .lastCompletedAddr);

	// --------------------
	// reference model
	// --------------------
	// increment of one select code this cycle; unknown codes add nothing
	function automatic logic [1:0] evInc(logic [4:0] c, bit four);
		logic [1:0] r;
		int         b;
		r = 2'h0;
		b = (timeBaseBitSelect == 2'h3) ? 0 : 16 - 4 * int'(timeBaseBitSelect);
		case (c)
			EV_CYCLES:      r = 2'h1;
			EV_COMPLETED:   r = commonEv.completed;
			EV_DISPATCHED:  r = commonEv.dispatched;
			EV_TIME_BASE:   r = 2'(timeBase[b] & ~tbPrev[b] & histM);
			EV_MARK_TOGGLE: r = 2'((markedProcessBit ^ markPrev) & histM
				& (four && !MARK_FOUR ? !userMode : userMode));
			default: for (int k = 0; k < 11; k++) begin
				if (!four && c == T3[k]) r = 2'(threeEv[10 - k]);
				if (four && k < 8 && c == T4[k]) r = 2'(fourEv[7 - k]);
			end
		endcase
		return r;
	endfunction : evInc

	// counters, interrupt, freeze and sample as the rules want them; write beats count
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cntM <= '{default: '0};
			{irqM, frzM, markPrev, tbPrev, sampM, histM} <= '0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				nx[k] = frzM ? cntM[k] : cntM[k] + 32'(k == 0 ? countOneInc : k == 1 ? countTwoInc
					: evInc(k == 2 ? controlSecond[4:0] : controlSecond[9:5], k == 3));
				if (wrReq && sprReq.num == NUMS[k < 2 ? k : k + 1]) nx[k] = sprReq.data;
			end
			irqN = globalIrqEnable && |({nx[3][31], nx[2][31], nx[1][31], nx[0][31]} & counterIrqControl);
			cntM     <= nx;
			irqM     <= irqN;
			frzM     <= stopOnIrq && (frzM || (irqN && !irqM));
			tbPrev   <= timeBase;
			markPrev <= markedProcessBit;
			histM    <= 1'b1;
			if (irqN && !irqM) sampM <= thresholdEvent ? thresholdAddr : lastCompletedAddr;
			else if (wrReq && sprReq.num == SPR_SAMPLED_ADDR) sampM <= sprReq.data;
		end
	end

	// --------------------
	// drivers and checks
	// --------------------
	function automatic note_s expectFor(logic wr, logic [9:0] num);
		note_s n;
		n = '{1'b1, 32'h0000_0000};
		case (num)
			SPR_COUNTER_ONE, SPR_USER_COUNTER_ONE:     n.data = cntM[0];
			SPR_COUNTER_TWO, SPR_USER_COUNTER_TWO:     n.data = cntM[1];
			SPR_COUNTER_THREE, SPR_USER_COUNTER_THREE: n.data = cntM[2];
			SPR_COUNTER_FOUR, SPR_USER_COUNTER_FOUR:   n.data = cntM[3];
			SPR_SAMPLED_ADDR, SPR_USER_SAMPLED_ADDR:   n.data = sampM;
			default:                                   n.hit = 1'b0;
		endcase
		if (wr) n.data = 32'h0000_0000;
		return n;
	endfunction : expectFor

	task automatic check(string what, logic [31:0] expv, logic [31:0] seen);
		cmp_count++;
		if (seen !== expv) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, expv, seen);
		end
	endtask : check

	// one-cycle request; valid stays up so a following call runs back to back
	task automatic access(logic wr, logic [9:0] num, logic [31:0] data);
		notes.push_back(expectFor(wr, num));
		sprReq = '{1'b1, wr, num, data};
		@(posedge clk_sys);
		#1;
	endtask : access

	task automatic idle(int n);
		repeat (n) begin
			sprReq.valid = 1'b0;
			@(posedge clk_sys);
			#1;
		end
	endtask : idle

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// oldest note against each answer; interrupt state every cycle
	always @(negedge clk_sys) begin
		if (rst_n) begin
			check("irq", irqM, monitorIrq);
			check("frozen", frzM, countersFrozen);
			check("sampled", sampM, sampledAddr);
			if (sprAck === 1'b1 && notes.size() > 0) begin
				got = notes.pop_front();
				check("hit", got.hit, sprHit);
				check("rddata", got.data, sprRdData);
			end else if (sprAck !== 1'b0 || notes.size() > int'(sprReq.valid)) begin
				check("ack", notes.size() > 0, sprAck);
				notes.delete();
			end
		end
	end

	initial begin
		#100000;
		check("run time", 32'h0, 32'h1);
		end_of_test();
	end

	initial begin
		void'($urandom(32'hEA7F52BB));
		repeat (12) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		// overflow of counter three with stop on interrupt, then mirrors and sample
		access(1'b1, SPR_COUNTER_THREE, 32'h7FFF_FFF8);
		controlSecond     = 32'h0000_0001;
		counterIrqControl = 4'h4;
		globalIrqEnable   = 1'b1;
		stopOnIrq         = 1'b1;
		idle(12);
		access(1'b1, SPR_USER_SAMPLED_ADDR, 32'h1234_5678);
		access(1'b1, SPR_SAMPLED_ADDR, 32'h0BAD_F00D);
		for (int i = 0; i < 11; i++) access(1'b0, NUMS[i], '0);
		stopOnIrq = 1'b0;
		idle(3);
		// every select code on both counters; hold one cycle while the time-base bit moves
		for (int p = 0; p < 32; p++) begin
			controlSecond = '0;
			timeBaseBitSelect = 2'($urandom);
			{globalIrqEnable, stopOnIrq, counterIrqControl} = 6'($urandom);
			idle(1);
			controlSecond = ($urandom & 32'hFFFF_FC00) | 32'(p) | (32'(31 - p) << 5);
			repeat (6) begin
				access(($urandom & 3) == 0, NUMS[$urandom_range(10)], $urandom);
				idle($urandom_range(3));
			end
		end
		idle(4);
		end_of_test();
	end
endmodule : test_perf_monitor_event_select

bind perf_monitor_event_select perf_monitor_event_select_asserts i_perf_monitor_event_select_asserts (.clk_sys,
	.rst_n, .sprReq, .sprAck, .sprHit, .sprRdData, .globalIrqEnable, .stopOnIrq, .thresholdEvent, .thresholdAddr,
	.lastCompletedAddr, .monitorIrq, .countersFrozen, .sampledAddr);
